//--- include/packet_link_pkg.sv
// shared constants and carrier types for the backplane packet link interface
// assumes 72-bit packet words moved as two 36-bit halves, upper half first
`default_nettype none

package packet_link_pkg;

	// link bus and packet word geometry
	localparam int HALF_W   = 36;
	localparam int WORD_W   = 72;
	// response flag: header bit 65, which is bit 29 of the upper half on the bus
	localparam int RESP_BIT = 29;
	// width of the free-space counts reported by the local receive queues
	localparam int FREE_W   = 9;
	// largest packet in packet words; a receive queue must hold this much to show ready
	localparam logic [FREE_W-1:0] MAX_PACKET_WORDS = 9'h083;

	// one 36-bit half as it sits on the link bus
	typedef logic [HALF_W-1:0] half_t;

	// a packet word: upper holds bits [71:36], lower holds bits [35:0]
	typedef struct packed
	{
		half_t upper;
		half_t lower;
	} pword_t;

	// a word offered for sending, with its end-of-packet mark (set on the checkword)
	typedef struct packed
	{
		logic   end_of_packet;
		pword_t word;
	} tx_item_t;

endpackage : packet_link_pkg

`default_nettype wire

//--- rtl/packet_link_handshake.sv
// board-side packet link interface: request, header, shift and receive toward the backplane arbiter
// assumes double_rate_clock runs at twice the reference rate, edge-aligned to it, so that
// arbiter controls change only between word slots; local queues live outside this block
`timescale 1ns/1ns
`default_nettype none

module packet_link_handshake
	import packet_link_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              system_reset_in,
	input  wire logic              is_backplane_controller,
	output logic                   backplane_reset_n,
	input  wire tx_item_t          tx_item,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire logic              hold_until_complete,
	input  wire logic              packet_complete,
	output pword_t                 rx_word,
	output logic                   rx_valid,
	input  wire logic [FREE_W-1:0] master_rx_free,
	input  wire logic [FREE_W-1:0] slave_rx_free,
	input  wire logic              double_rate_clock,
	output logic                   packet_request_n,
	input  wire logic              header_select_n,
	input  wire logic              source_shift,
	input  wire logic              dest_shift,
	output logic                   word_valid_n,
	output logic                   master_rx_ready,
	output logic                   slave_rx_ready,
	input  wire half_t             link_data_in,
	output half_t                  link_data_out,
	output logic                   link_data_oe
);

	// system clock side state
	typedef struct packed
	{
		logic     sysrst_meta;
		logic     sysrst_sync;
		logic     ctrl_meta;
		logic     ctrl_sync;
		logic     bp_reset_n;
		logic     link_rst_req;
		tx_item_t hold;
		logic     hold_full;
		logic     req_tog;
		logic     ack_meta;
		logic     ack_sync;
		logic     master_space_ok;
		logic     slave_space_ok;
	} sys_state_t;

	// link clock side state
	typedef struct packed
	{
		logic     rst_meta;
		logic     rst;
		logic     req_meta;
		logic     req_sync;
		logic     ack_tog;
		logic     pend_meta;
		logic     pend_sync;
		logic     cmpl_meta;
		logic     cmpl_sync;
		logic     mrdy_meta;
		logic     mrdy;
		logic     srdy_meta;
		logic     srdy;
		tx_item_t word;
		logic     word_full;
		logic     phase;
		logic     in_packet;
		logic     request_n;
		logic     valid_n;
		half_t    data_out;
		half_t    rx_upper;
		logic     rx_push;
		pword_t   rx_word;
	} link_state_t;

	sys_state_t  sy;
	sys_state_t  next_sy;
	link_state_t lk;
	link_state_t next_lk;

	logic sys_clear;
	logic shifting;
	logic eligible;

	// local reset or the synchronised system reset pin clears the interface
	assign sys_clear = reset | sy.sysrst_sync;

	// system side: reset pin sync, backplane reset mirror, send handshake, queue space checks
	always_comb
	begin
		next_sy             = sy;
		next_sy.sysrst_meta = system_reset_in;
		next_sy.sysrst_sync = sy.sysrst_meta;
		next_sy.ctrl_meta   = is_backplane_controller;
		next_sy.ctrl_sync   = sy.ctrl_meta;
		// on the controller board, backplane reset lasts exactly as long as the synchronised pin, delayed one clock
		next_sy.bp_reset_n   = ~(sy.sysrst_sync & sy.ctrl_sync);
		next_sy.link_rst_req = sys_clear;
		next_sy.ack_meta     = lk.ack_tog;
		next_sy.ack_sync     = sy.ack_meta;
		// a queue shows ready only while it can swallow a whole maximum packet
		next_sy.master_space_ok = (master_rx_free >= MAX_PACKET_WORDS);
		next_sy.slave_space_ok  = (slave_rx_free >= MAX_PACKET_WORDS);
		// the link has copied the held word once its acknowledge toggle catches up
		if (sy.hold_full && (sy.ack_sync == sy.req_tog))
			next_sy.hold_full = 1'h0;
		if (tx_valid && tx_ready)
		begin
			next_sy.hold      = tx_item;
			next_sy.hold_full = 1'h1;
			next_sy.req_tog   = ~sy.req_tog;
		end
		if (sy.sysrst_sync)
		begin
			next_sy.hold_full = 1'h0;
			next_sy.req_tog   = 1'h0;
		end
	end

	// a new word is taken only while the hold register is free, which stalls the source
	assign tx_ready = ~sy.hold_full & ~sys_clear;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			sy              <= '0;
			sy.bp_reset_n   <= 1'h1;
			// local reset must reach the link side too, or its state survives the reset
			sy.link_rst_req <= 1'h1;
		end
		else
			sy <= next_sy;
	end

	assign backplane_reset_n = sy.bp_reset_n;

	// source shifting only counts inside a live connection
	assign shifting = source_shift & ~header_select_n;

	// a held header may raise the request unless a slow master waits for the whole packet;
	// response packets never wait, so read latency stays short
	assign eligible = next_lk.word_full
		& (~lk.pend_sync | lk.cmpl_sync | next_lk.word.word.upper[RESP_BIT]);

	// link side: word fetch, half sequencing, request and valid, receive capture
	always_comb
	begin
		next_lk           = lk;
		next_lk.rst_meta  = sy.link_rst_req;
		next_lk.rst       = lk.rst_meta;
		next_lk.req_meta  = sy.req_tog;
		next_lk.req_sync  = lk.req_meta;
		next_lk.pend_meta = hold_until_complete;
		next_lk.pend_sync = lk.pend_meta;
		next_lk.cmpl_meta = packet_complete;
		next_lk.cmpl_sync = lk.cmpl_meta;
		next_lk.mrdy_meta = sy.master_space_ok;
		next_lk.mrdy      = lk.mrdy_meta;
		next_lk.srdy_meta = sy.slave_space_ok;
		next_lk.srdy      = lk.srdy_meta;
		next_lk.rx_push   = 1'h0;
		// phase 0 edges carry upper halves, phase 1 edges lower halves
		next_lk.phase     = ~lk.phase;

		// lower edge of a shifted word: the word is gone, in_packet follows its end-of-packet mark
		if (shifting && lk.word_full && !lk.valid_n && lk.phase)
		begin
			next_lk.word_full = 1'h0;
			next_lk.in_packet = ~lk.word.end_of_packet;
		end
		else if (shifting && !lk.valid_n)
			next_lk.in_packet = 1'h1;

		// fetch only on word boundaries so word-valid changes at reference clock edges
		if (lk.phase && !next_lk.word_full && (lk.req_sync != lk.ack_tog))
		begin
			next_lk.word      = sy.hold;
			next_lk.word_full = 1'h1;
			next_lk.ack_tog   = lk.req_sync;
		end

		// upper half goes out first; only an upper-slot shift swaps in the lower half
		if (shifting && !lk.valid_n && !lk.phase)
			next_lk.data_out = lk.word.word.lower;
		else
			next_lk.data_out = next_lk.word.word.upper;

		// valid follows word presence, so an empty hold pauses the arbiter's shifting
		next_lk.valid_n = ~next_lk.word_full;

		// request rules: early request, hold to grant, then drop for the rest of the packet
		if (next_lk.in_packet)
			next_lk.request_n = 1'h1;
		else if (!lk.request_n && next_lk.word_full)
			next_lk.request_n = 1'h0;
		else
			next_lk.request_n = ~eligible;

		// receive: catch upper on one edge, complete the word on the next
		if (dest_shift && !lk.phase)
			next_lk.rx_upper = link_data_in;
		if (dest_shift && lk.phase)
		begin
			next_lk.rx_word.upper = lk.rx_upper;
			next_lk.rx_word.lower = link_data_in;
			next_lk.rx_push       = 1'h1;
		end
	end

	// link reset keeps its own synchroniser running, parks request and valid high and clears all else
	always_ff @(posedge double_rate_clock)
	begin
		if (lk.rst)
		begin
			lk           <= '0;
			lk.rst_meta  <= sy.link_rst_req;
			lk.rst       <= lk.rst_meta;
			lk.request_n <= 1'h1;
			lk.valid_n   <= 1'h1;
		end
		else
			lk <= next_lk;
	end

	// pin drivers; the bus is driven only under header select, so close floats it
	assign packet_request_n = lk.request_n;
	assign word_valid_n     = lk.valid_n;
	assign master_rx_ready  = lk.mrdy & ~lk.rst;
	assign slave_rx_ready   = lk.srdy & ~lk.rst;
	assign link_data_out    = lk.data_out;
	assign link_data_oe     = ~header_select_n & ~lk.rst;

	// received words cross to the system clock through a two-slot ring
	rx_word_crossing u_rx_crossing
	(
		.clk_link   (double_rate_clock),
		.link_reset (lk.rst),
		.push       (lk.rx_push),
		.push_word  (lk.rx_word),
		.clk_sys    (clk_sys),
		.sys_reset  (sys_clear),
		.pop_word   (rx_word),
		.pop_valid  (rx_valid)
	);

endmodule : packet_link_handshake

`default_nettype wire

//--- rtl/rx_word_crossing.sv
// carries received packet words from the link clock domain to the system clock domain
// assumes pushes arrive at least two link clocks apart and the system clock drains one word a cycle
`timescale 1ns/1ns
`default_nettype none

module rx_word_crossing
	import packet_link_pkg::*;
(
	input  wire logic    clk_link,
	input  wire logic    link_reset,
	input  wire logic    push,
	input  wire pword_t  push_word,
	input  wire logic    clk_sys,
	input  wire logic    sys_reset,
	output pword_t       pop_word,
	output logic         pop_valid
);

	// writer side: two slots used in turn, so a slot stays still while the reader copies it
	typedef struct packed
	{
		pword_t [1:0] slot;
		logic         wr_idx;
	} wr_state_t;

	// reader side: synchronised write index, own read index, output word
	typedef struct packed
	{
		logic   idx_meta;
		logic   idx_sync;
		logic   rd_idx;
		pword_t word;
		logic   valid;
	} rd_state_t;

	wr_state_t wr;
	wr_state_t next_wr;
	rd_state_t rd;
	rd_state_t next_rd;

	// write a slot and flip the index; the index flip is the event that crosses
	always_comb
	begin
		next_wr = wr;
		if (push)
		begin
			next_wr.slot[wr.wr_idx] = push_word;
			next_wr.wr_idx          = ~wr.wr_idx;
		end
	end

	always_ff @(posedge clk_link)
	begin
		if (link_reset)
			wr <= '0;
		else
			wr <= next_wr;
	end

	// a differing synchronised index means a filled slot that is safe to copy
	always_comb
	begin
		next_rd          = rd;
		next_rd.idx_meta = wr.wr_idx;
		next_rd.idx_sync = rd.idx_meta;
		next_rd.valid    = 1'h0;
		if (rd.idx_sync != rd.rd_idx)
		begin
			next_rd.word   = wr.slot[rd.rd_idx];
			next_rd.valid  = 1'h1;
			next_rd.rd_idx = ~rd.rd_idx;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_reset)
			rd <= '0;
		else
			rd <= next_rd;
	end

	assign pop_word  = rd.word;
	assign pop_valid = rd.valid;

endmodule : rx_word_crossing

`default_nettype wire

//--- test/arbiter_model.sv
// arbiter model: selects, checks room, shifts and closes packets
// assumes the destination is the same interface, so words loop back on the bus
`timescale 1ns/1ns
`default_nettype none
module arbiter_model
	import packet_link_pkg::*;
(
	input  wire logic  double_rate_clock,
	input  wire logic  reset,
	input  wire logic  slow,
	input  wire logic  packet_request_n,
	input  wire logic  word_valid_n,
	input  wire logic  master_rx_ready,
	input  wire logic  slave_rx_ready,
	input  wire logic  link_data_oe,
	input  wire half_t link_data_out,
	output logic       header_select_n,
	output logic       source_shift,
	output logic       dest_shift,
	output half_t      link_data_in
);
	logic [1:0] rs = 2'b11;
	logic       ph = 1'b0;
	half_t      last = '0;
	int         st, cnt, len, gap;
	initial
	begin
		header_select_n = 1'b1;
		source_shift = 1'b0;
	end
	// a released bus shows the inverse of its last value, never a stale copy
	assign link_data_in = link_data_oe ? link_data_out : ~last;
	// a shift slot with word-valid high carries nothing, so the destination must not take it
	assign dest_shift = source_shift && !word_valid_n; // loopback destination
	// controls change after phase-1 edges only, once per reference clock
	always @(posedge double_rate_clock)
	begin
		rs <= {rs[0], reset};
		ph <= rs[1] ? 1'b0 : ~ph;
		if (link_data_oe)
			last <= link_data_out;
		if (reset)
		begin
			st = 0;
			header_select_n <= 1'b1;
			source_shift <= 1'b0;
		end
		else if (ph)
			case (st)
			0: if (!packet_request_n && !word_valid_n)
			begin
				header_select_n <= 1'b0;
				st = 1;
				gap = 0;
			end
			1: if (word_valid_n)
			begin
				header_select_n <= 1'b1;
				st = 0;
			end
			else if (gap++ >= (slow ? 6 : 0))
				// every board position counts as populated here
				if (link_data_out[RESP_BIT] ? master_rx_ready : slave_rx_ready)
				begin
					source_shift <= 1'b1;
					cnt = 0;
					st = 2;
				end
				else
				begin
					header_select_n <= 1'b1;
					st = 0;
				end
			default:
			begin
				if (cnt == 0)
					len = int'(link_data_out[7:0]);
				cnt += int'(source_shift && !word_valid_n);
				source_shift <= !word_valid_n;
				if (cnt == len)
				begin
					header_select_n <= 1'b1;
					source_shift <= 1'b0;
					st = 0;
				end
			end
			endcase
	end
endmodule : arbiter_model
`default_nettype wire

//--- test/packet_link_handshake_props.sv
// checker for the packet link interface, watching its ports only
// assumes clk_sys resets synchronously and the link runs on double_rate_clock
`timescale 1ns/1ns
`default_nettype none
module packet_link_handshake_props
	import packet_link_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              reset,
	input wire logic              system_reset_in,
	input wire logic              is_backplane_controller,
	input wire logic              backplane_reset_n,
	input wire logic              tx_ready,
	input wire logic              rx_valid,
	input wire logic [FREE_W-1:0] master_rx_free,
	input wire logic [FREE_W-1:0] slave_rx_free,
	input wire logic              double_rate_clock,
	input wire logic              packet_request_n,
	input wire logic              header_select_n,
	input wire logic              source_shift,
	input wire logic              word_valid_n,
	input wire logic              master_rx_ready,
	input wire logic              slave_rx_ready,
	input wire logic              link_data_oe
);
	// either reset pin clears the block, so both mute the checks other than the reset-quiet and backplane reset ones
	wire logic any_rst = reset | system_reset_in;
	// grant and wait steps of the request handshake
	sequence grant_s;
		source_shift && !word_valid_n && !packet_request_n;
	endsequence
	sequence wait_s;
		!packet_request_n && !source_shift;
	endsequence
	sys_quiet_a: assert property (@(posedge clk_sys) reset [*2] |-> !tx_ready && !rx_valid)
		else $error("local side active in reset");
	link_quiet_a: assert property (@(posedge double_rate_clock) reset [*4] |->
		packet_request_n && word_valid_n && !link_data_oe && !master_rx_ready) else $error("link active in reset");
	drive_on_a: assert property (@(posedge double_rate_clock) disable iff (any_rst)
		$fell(header_select_n) |-> link_data_oe && !word_valid_n) else $error("header not driven");
	req_hold_a: assert property (@(posedge double_rate_clock) disable iff (any_rst)
		wait_s |=> !packet_request_n) else $error("request dropped before grant");
	req_drop_a: assert property (@(posedge double_rate_clock) disable iff (any_rst)
		grant_s |=> packet_request_n) else $error("request kept after grant");
	hdr_ready_a: assert property (@(posedge double_rate_clock) disable iff (any_rst)
		$fell(packet_request_n) |-> !word_valid_n) else $error("request without header word");
	m_low_a: assert property (@(posedge clk_sys) disable iff (any_rst)
		(master_rx_free < MAX_PACKET_WORDS) [*5] |-> !master_rx_ready) else $error("master ready too early");
	s_low_a: assert property (@(posedge clk_sys) disable iff (any_rst)
		(slave_rx_free < MAX_PACKET_WORDS) [*5] |-> !slave_rx_ready) else $error("slave ready too early");
	m_high_a: assert property (@(posedge clk_sys) disable iff (any_rst)
		(master_rx_free >= MAX_PACKET_WORDS) [*8] ##1 (master_rx_free >= MAX_PACKET_WORDS) [*4] |->
		master_rx_ready) else $error("master ready missing");
	bp_reset_a: assert property (@(posedge clk_sys)
		(system_reset_in && is_backplane_controller) [*4] |-> !backplane_reset_n) else $error("no backplane reset");
	bp_idle_a: assert property (@(posedge clk_sys)
		(!system_reset_in) [*4] |-> backplane_reset_n) else $error("stray backplane reset");
	rx_pulse_a: assert property (@(posedge clk_sys) disable iff (any_rst)
		rx_valid |=> !rx_valid) else $error("receive pulse too long");
endmodule : packet_link_handshake_props
bind packet_link_handshake packet_link_handshake_props packet_link_handshake_props_i (.*);
`default_nettype wire

//--- test/packet_link_handshake_tb_top.sv
// bench: packets sent locally loop back through the arbiter model
// assumes arbiter_model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module packet_link_handshake_tb_top
	import packet_link_pkg::*;
();
	logic              clk_sys = 1'b0;
	logic              double_rate_clock = 1'b0;
	logic              reset = 1'b1;
	logic              system_reset_in = 1'b0;
	logic              is_backplane_controller = 1'b0;
	logic              hold_until_complete = 1'b0;
	logic              packet_complete = 1'b0;
	logic              tx_valid = 1'b0;
	logic              slow = 1'b0;
	logic [FREE_W-1:0] master_rx_free = 9'h0FF;
	logic [FREE_W-1:0] slave_rx_free = 9'h083;
	tx_item_t          tx_item = '0;
	// arbiter reset released in step with the block's link reset, so word slots line up
	logic              arb_rst = 1'b1;
	logic [1:0]        sr = 2'b00;
	logic              backplane_reset_n, tx_ready, rx_valid, packet_request_n, header_select_n;
	logic              source_shift, dest_shift, word_valid_n, master_rx_ready, slave_rx_ready, link_data_oe;
	pword_t            rx_word;
	half_t             link_data_in, link_data_out;
	int                fail_count = 0;
	int                cmp_count = 0;
	logic [15:0]       lf = 16'h4586;
	pword_t            exp_q[$];
	// sys rising edges fall on odd times, link edges on even, so they never meet
	always #25 clk_sys = ~clk_sys;
	initial
	begin
		#10;
		forever #32 double_rate_clock = ~double_rate_clock;
	end
	packet_link_handshake packet_link_handshake_i (.*);
	always @(posedge clk_sys)
	begin
		sr      <= {sr[0], system_reset_in};
		arb_rst <= reset | sr[1];
	end
	arbiter_model arbiter_model_i (.*, .reset(arb_rst));
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// one packet; header holds the response flag and the length in words
	task automatic send(input int len, input logic resp);
		pword_t w;
		int     t;
		for (int i = 0; i < len; i++)
		begin
			lf = lfsr(lf);
			w = {lf[7:0], lf, ~lf, lf ^ 16'h5A5A, lf};
			if (i == 0)
				w.upper[RESP_BIT] = resp;
			if (i == 0)
				w.lower[7:0] = len[7:0];
			tx_item = {i == len - 1, w};
			tx_valid = 1'b1;
			t = 0;
			do
				@(posedge clk_sys);
			while (tx_ready !== 1'b1 && ++t < 500);
			exp_q.push_back(w);
			#2 tx_valid = lf[3] | lf[9];
			if (!tx_valid)
				#50;
		end
		tx_valid = 1'b0;
	endtask : send
	task automatic drain;
		int t = 0;
		while (exp_q.size() != 0 && t++ < 3000)
			@(posedge clk_sys);
		#2 check(72'(exp_q.size()), 72'(0));
	endtask : drain
	task automatic probe(input int n, input logic v);
		repeat (n) @(posedge clk_sys);
		#2 check(packet_request_n, v);
	endtask : probe
	// every received word must be the oldest one sent, upper half first
	always @(posedge clk_sys)
		if (rx_valid === 1'b1)
			check(rx_word, exp_q.size() != 0 ? exp_q.pop_front() : '1);
	initial
	begin
		#3_000_000;
		fail_count++;
		stop_test;
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		#2 check({packet_request_n, word_valid_n, link_data_oe, master_rx_ready}, 4'b1100);
		reset = 1'b0;
		repeat (12) @(posedge clk_sys);
		#2 check({master_rx_ready, slave_rx_ready}, 2'b11);
		send(3, 1'b0);
		send(3, 1'b1);
		send(131, 1'b0);
		send(4 + int'(lf[2:0]), 1'b1);
		drain;
		// destination short of room: refused and retried until room appears
		master_rx_free = 9'h082;
		slave_rx_free = 9'h082;
		fork
			send(4, 1'b1);
			begin
				probe(60, 1'b0);
				check({master_rx_ready, slave_rx_ready}, 2'b00);
				master_rx_free = 9'h083;
				slave_rx_free = 9'h083;
			end
		join
		drain;
		// slow arbiter; slow master holds its request until the packet is whole
		slow = 1'b1;
		hold_until_complete = 1'b1;
		fork
			send(3, 1'b0);
			begin
				probe(30, 1'b1);
				packet_complete = 1'b1;
			end
		join
		drain;
		packet_complete = 1'b0;
		fork
			send(3, 1'b1);
			probe(9, 1'b0);
		join
		drain;
		// system reset on the controller board, then traffic again
		hold_until_complete = 1'b0;
		slow = 1'b0;
		is_backplane_controller = 1'b1;
		system_reset_in = 1'b1;
		repeat (8) @(posedge clk_sys);
		#2 check({backplane_reset_n, tx_ready, master_rx_ready}, 3'b000);
		system_reset_in = 1'b0;
		repeat (8) @(posedge clk_sys);
		#2 check(backplane_reset_n, 1'b1);
		is_backplane_controller = 1'b0;
		send(3, 1'b0);
		drain;
		stop_test;
	end
endmodule : packet_link_handshake_tb_top
`default_nettype wire
